/* File: analog_output_sequencer_consts.vh */
// Purpose: Constants for the analog output sequencer
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes: Definitions only
`ifndef ANALOG_OUTPUT_SEQUENCER_CONSTS_VH
`define ANALOG_OUTPUT_SEQUENCER_CONSTS_VH
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_PERIOD 8'h08
`define REG_SAMPLES 8'h0c
`define REG_REPEAT 8'h10
`define REG_XFER_LEVEL 8'h14
`define REG_DATA 8'h18
`define REG_STATUS 8'h1c
`define REG_EVENTS 8'h20
`define REG_FILL 8'h24
`define REG_SAMPLE_CNT 8'h28
`define REG_REPEAT_DONE 8'h2c
`define REG_TIMEOUT 8'h30
`define CTRL_RING 0
`define CTRL_CLK_EXT 1
`define CTRL_CLK_FALL 2
`define CTRL_START_EXT 3
`define CTRL_START_FALL 4
`define CTRL_STOP_LO 5
`define CTRL_STOP_HI 6
`define CTRL_STOP_FALL 7
`define CTRL_NCH_LO 8
`define CTRL_NCH_HI 9
`define STOP_COUNT 2'h0
`define STOP_EXT 2'h1
`define STOP_SW 2'h2
`define CMD_START 0
`define CMD_STOP 1
`define CMD_STAT_RST 2
`define CMD_MEM_RST 3
`define ST_BUSY 0
`define ST_TRIG_WAIT 1
`define ST_DATA_CNT 2
`define ST_SCLK_ERR 3
`define ST_CONV_ERR 4
`define ST_OVERFLOW 5
`define ST_REFUSED 6
`define EV_START 0
`define EV_REP_END 1
`define EV_OP_END 2
`define EV_NSAMP 3
`define EV_XFER 4
`define EV_SCLK_ERR 5
`define EV_CONV_ERR 6
`define MEM_DEPTH 11'h400
`define DAC_MID 16'h8000
`define CTRL_RST 10'h000
`define PERIOD_RST 24'h0000fa
`define SAMPLES_RST 16'h0001
`define REPEAT_RST 16'h0001
`define XFER_LEVEL_RST 16'h0000
`define TIMEOUT_RST 32'h00000000
`endif

/* File: analog_output_sequencer.v */
// Purpose: Sample memory, sequencing and status for a multi-channel 16-bit output
// Assumes: APB master, ext inputs asynchronous to pclk, one word per channel per sample
// Notes: No interrupt line; events are sticky bits cleared by writing ones
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "analog_output_sequencer_consts.vh"

// How it works
// [R01] FIFO: writes append after newest word, oldest is output first, writes allowed while running.
// [R02] FIFO write beyond capacity flags overflow but output keeps running.
// [R03] Host loads one full waveform period before starting in ring format.
// [R04] Ring format: writes during output are refused and flagged.
// [R05] Repeat count used only in ring format; pattern replayed that many times.
// [R06] Repeat count zero means cycle forever until software stop.
// [R07] Control bit selects internal divider or external clock edge as sample clock.
// [R08] Software start: output begins immediately after the start command.
// [R09] External start: wait state, output begins on chosen trigger edge.
// [R10] Any halting error stops sampling whatever the stop condition.
// [R11] Count stop: stop after the programmed number of samples.
// [R12] External stop: finish sample count, then stop on chosen trigger edge.
// [R13] Software stop: run without limit until stop command or error.
// [R14] Start-satisfied event on trigger start only, never with software start.
// [R15] Repeat-end event per repetition, end-of-operation event when all done.
// [R16] Transfer event: FIFO while fill below level; ring when count reaches level.
// [R17] Sample tick during unfinished burst is a clock error: stop, flag, event.
// [R18] Busy flag from start until completion, error or stop command.
// [R19] Trigger-wait flag set on each entry to start wait, cleared at trigger.
// [R20] Data-count flag set when stored words reach the programmed sample count times the channel count.
// [R21] Status reset command clears clock error and conversion error flags.
// [R22] Memory reset clears data, sample count, data-count flag, completed repeat count.
// [R23] Codes are offset binary; mid code is zero volts.
module analog_output_sequencer (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_clk_in,
  input wire ext_trig_in,
  output reg [15:0] dac_data,
  output reg [1:0] dac_chan,
  output reg dac_load,
  output reg running
);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_WAIT_START = 4'h2;
  localparam [3:0] S_RUN = 4'h4;
  localparam [3:0] S_WAIT_STOP = 4'h8;

  reg [9:0] ctrl;
  reg [23:0] period;
  reg [15:0] samples;
  reg [15:0] repeat_cnt;
  reg [15:0] xfer_level;
  reg [31:0] timeout;
  reg [6:0] events;
  reg sclk_err;
  reg conv_err;
  reg overflow;
  reg refused;
  reg [15:0] mem [0:1023];
  reg [9:0] wr_ptr;
  reg [9:0] rd_ptr;
  reg [10:0] fill;
  reg [3:0] state;
  reg trig_wait;
  reg [23:0] div_cnt;
  reg [15:0] sample_cnt;
  reg [15:0] repeat_done;
  reg [2:0] burst_left;
  reg [1:0] burst_ch;
  reg [31:0] wd_cnt;
  reg clk_s1, clk_s2, clk_s3;
  reg trig_s1, trig_s2, trig_s3;

  function edge_hit;
    input prev;
    input cur;
    input fall;
    begin
      edge_hit = fall ? (prev & ~cur) : (~prev & cur);
    end
  endfunction

  function [17:0] words_of;
    input [15:0] n;
    input [1:0] m;
    begin
      words_of = {2'b00, n} * {16'h0000, m} + {2'b00, n};
    end
  endfunction

  wire ring = ctrl[`CTRL_RING];
  wire [1:0] nch_m1 = ctrl[`CTRL_NCH_HI:`CTRL_NCH_LO];
  wire [1:0] stop_sel = ctrl[`CTRL_STOP_HI:`CTRL_STOP_LO];
  wire busy = (state != S_IDLE);
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  wire cmd_wr = apb_wr & (paddr == `REG_CMD);
  wire start_cmd = cmd_wr & pwdata[`CMD_START] & (state == S_IDLE);
  wire stop_cmd = cmd_wr & pwdata[`CMD_STOP];
  wire stat_rst = cmd_wr & pwdata[`CMD_STAT_RST];
  wire mem_rst = cmd_wr & pwdata[`CMD_MEM_RST];
  wire data_wr = apb_wr & (paddr == `REG_DATA);
  wire ring_block = data_wr & ring & busy; // [R04]
  wire mem_full = (fill == `MEM_DEPTH);
  wire mem_accept = data_wr & ~ring_block & ~mem_full & ~mem_rst; // [R01]
  wire mem_over = data_wr & ~ring_block & mem_full; // [R02]
  wire burst_on = (burst_left != 3'h0);
  wire pop = burst_on & ~ring;
  wire [17:0] sample_words = words_of(samples, nch_m1);
  wire [10:0] nch_words = {9'h000, nch_m1} + 11'h001;
  wire [23:0] reload = (period == 24'h000000) ? 24'h000000 : period - 24'h000001;
  wire int_tick = (div_cnt == 24'h000000);
  wire ext_tick = edge_hit(clk_s3, clk_s2, ctrl[`CTRL_CLK_FALL]);
  wire tick = (state == S_RUN) & (ctrl[`CTRL_CLK_EXT] ? ext_tick : int_tick); // [R07]
  wire start_edge = edge_hit(trig_s3, trig_s2, ctrl[`CTRL_START_FALL]);
  wire stop_edge = edge_hit(trig_s3, trig_s2, ctrl[`CTRL_STOP_FALL]);
  wire underrun = tick & (fill < nch_words);
  wire sclk_fault = tick & burst_on; // [R17]
  wire wd_fault = busy & (timeout != 32'h00000000) & (wd_cnt == timeout - 32'h00000001);
  wire conv_fault = (underrun & ~burst_on) | wd_fault;
  wire halt = sclk_fault | conv_fault; // [R10]
  wire good_tick = tick & ~halt;
  wire [15:0] sample_inc = sample_cnt + 16'h0001;
  wire [15:0] repeat_inc = repeat_done + 16'h0001;
  wire rep_end = good_tick & (sample_inc == samples);
  wire more_reps = (stop_sel == `STOP_SW) | (repeat_cnt == 16'h0000) |
                   (repeat_inc < repeat_cnt); // [R06]
  wire [10:0] rd_inc = {1'b0, rd_ptr} + 11'h001;
  wire [10:0] rd_wrap = (rd_inc >= fill) ? 11'h000 : rd_inc;
  wire [9:0] rd_next = ring ? rd_wrap[9:0] : rd_inc[9:0];
  wire [6:0] ev_clr = (apb_wr & (paddr == `REG_EVENTS)) ? pwdata[6:0] : 7'h00;
  wire [6:0] status = {refused, overflow, conv_err, sclk_err,
                       ({7'h00, fill} >= sample_words), trig_wait, busy}; // [R20]

  reg [6:0] ev_set;
  reg [3:0] next_state;
  always @* begin
    ev_set = 7'h00;
    next_state = state;
    if (sclk_fault) begin
      ev_set[`EV_SCLK_ERR] = 1'b1; // [R17]
    end
    if (conv_fault & ~sclk_fault) begin
      ev_set[`EV_CONV_ERR] = 1'b1;
    end
    if (tick & ~halt & ~ring & ({5'h00, fill} < xfer_level)) begin
      ev_set[`EV_XFER] = 1'b1; // [R16]
    end
    if (good_tick & ring & (sample_inc == xfer_level)) begin
      ev_set[`EV_XFER] = 1'b1; // [R16]
    end
    if (halt | stop_cmd) begin
      next_state = S_IDLE; // [R18]
    end else begin
      case (state)
        S_IDLE: begin
          if (start_cmd) begin
            next_state = ctrl[`CTRL_START_EXT] ? S_WAIT_START : S_RUN; // [R08] [R09]
          end
        end
        S_WAIT_START: begin
          if (start_edge) begin
            next_state = S_RUN; // [R09]
            ev_set[`EV_START] = 1'b1; // [R14]
          end
        end
        S_RUN: begin
          if (rep_end) begin
            ev_set[`EV_NSAMP] = 1'b1;
            if (ring) begin
              ev_set[`EV_REP_END] = 1'b1; // [R15]
            end
            if (ring & more_reps) begin
              next_state = ctrl[`CTRL_START_EXT] ? S_WAIT_START : S_RUN; // [R05] [R19]
            end else if (stop_sel == `STOP_SW) begin
              next_state = S_RUN; // [R13]
            end else if (stop_sel == `STOP_EXT) begin
              next_state = S_WAIT_STOP; // [R12]
            end else begin
              next_state = S_IDLE; // [R11]
              ev_set[`EV_OP_END] = 1'b1; // [R15]
            end
          end
        end
        S_WAIT_STOP: begin
          if (stop_edge) begin
            next_state = S_IDLE; // [R12]
            ev_set[`EV_OP_END] = 1'b1;
          end
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  // Both external inputs are asynchronous; stage 1 feeds stage 2 only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      clk_s1 <= ext_clk_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      trig_s1 <= ext_trig_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // Zero-wait slave: read data staged in setup, access completes at next edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_setup) begin
        case (paddr)
          `REG_CTRL: prdata <= {22'h000000, ctrl};
          `REG_CMD: prdata <= 32'h00000000;
          `REG_PERIOD: prdata <= {8'h00, period};
          `REG_SAMPLES: prdata <= {16'h0000, samples};
          `REG_REPEAT: prdata <= {16'h0000, repeat_cnt};
          `REG_XFER_LEVEL: prdata <= {16'h0000, xfer_level};
          `REG_DATA: prdata <= 32'h00000000;
          `REG_STATUS: prdata <= {25'h0000000, status};
          `REG_EVENTS: prdata <= {25'h0000000, events};
          `REG_FILL: prdata <= {21'h000000, fill};
          `REG_SAMPLE_CNT: prdata <= {16'h0000, sample_cnt};
          `REG_REPEAT_DONE: prdata <= {16'h0000, repeat_done};
          `REG_TIMEOUT: prdata <= timeout;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Mode is frozen while busy so a run never changes format mid-flight
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RST;
      period <= `PERIOD_RST;
      samples <= `SAMPLES_RST;
      repeat_cnt <= `REPEAT_RST;
      xfer_level <= `XFER_LEVEL_RST;
      timeout <= `TIMEOUT_RST;
    end else if (apb_wr & ~busy) begin
      case (paddr)
        `REG_CTRL: ctrl <= pwdata[9:0];
        `REG_PERIOD: period <= pwdata[23:0];
        `REG_SAMPLES: samples <= pwdata[15:0];
        `REG_REPEAT: repeat_cnt <= pwdata[15:0];
        `REG_XFER_LEVEL: xfer_level <= pwdata[15:0];
        `REG_TIMEOUT: timeout <= pwdata;
        default: ;
      endcase
    end
  end

  // Flags: a set in the same cycle as its clear wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= 7'h00;
      sclk_err <= 1'b0;
      conv_err <= 1'b0;
      overflow <= 1'b0;
      refused <= 1'b0;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
      sclk_err <= (sclk_err & ~stat_rst) | sclk_fault; // [R21]
      conv_err <= (conv_err & ~stat_rst) | (conv_fault & ~sclk_fault); // [R21]
      overflow <= (overflow & ~mem_rst) | mem_over; // [R02]
      refused <= (refused & ~stat_rst) | ring_block; // [R04]
    end
  end

  always @(posedge pclk) begin
    if (mem_accept) begin
      mem[wr_ptr] <= pwdata[15:0]; // [R01]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 10'h000;
      rd_ptr <= 10'h000;
      fill <= 11'h000;
    end else if (mem_rst) begin
      wr_ptr <= 10'h000; // [R22]
      rd_ptr <= 10'h000;
      fill <= 11'h000;
    end else begin
      if (mem_accept) begin
        wr_ptr <= wr_ptr + 10'h001;
      end
      if (start_cmd & ring) begin
        rd_ptr <= 10'h000;
      end else if (burst_on) begin
        rd_ptr <= rd_next; // [R01]
      end
      if (mem_accept & ~pop) begin
        fill <= fill + 11'h001;
      end else if (pop & ~mem_accept) begin
        fill <= fill - 11'h001;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      trig_wait <= 1'b0;
      div_cnt <= 24'h000000;
      sample_cnt <= 16'h0000;
      repeat_done <= 16'h0000;
      wd_cnt <= 32'h00000000;
      running <= 1'b0;
    end else begin
      state <= next_state;
      running <= (next_state != S_IDLE); // [R18]
      trig_wait <= (next_state == S_WAIT_START); // [R19]
      if (next_state == S_RUN & state != S_RUN) begin
        div_cnt <= 24'h000000;
      end else if (state == S_RUN) begin
        div_cnt <= int_tick ? reload : div_cnt - 24'h000001;
      end
      if (start_cmd) begin
        wd_cnt <= 32'h00000000;
      end else if (busy) begin
        wd_cnt <= wd_cnt + 32'h00000001;
      end
      if (start_cmd | mem_rst) begin
        sample_cnt <= 16'h0000; // [R22]
        repeat_done <= 16'h0000; // [R22]
      end else if (rep_end) begin
        sample_cnt <= 16'h0000;
        if (ring) begin
          repeat_done <= repeat_inc; // [R05]
        end
      end else if (good_tick) begin
        sample_cnt <= sample_inc;
      end
    end
  end

  // One sample is a burst of one word per enabled channel
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_left <= 3'h0;
      burst_ch <= 2'h0;
      dac_data <= `DAC_MID; // [R23]
      dac_chan <= 2'h0;
      dac_load <= 1'b0;
    end else begin
      dac_load <= 1'b0;
      if (good_tick) begin
        burst_left <= {1'b0, nch_m1} + 3'h1;
        burst_ch <= 2'h0;
      end else if (burst_on) begin
        dac_data <= mem[rd_ptr]; // [R23]
        dac_chan <= burst_ch;
        dac_load <= 1'b1;
        burst_ch <= burst_ch + 2'h1;
        burst_left <= burst_left - 3'h1;
      end
    end
  end
endmodule // analog_output_sequencer

/* File: apb_host.sv */
// Purpose: APB host model that loads samples and issues commands
// Assumes: Slave raises pready in the access phase
// Notes: Released write data is inverted so stale values never pass
`timescale 1ns/1ps
module apb_host (
  input wire pclk,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 64) tb_analog_output_sequencer.hang();
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // apb_host

/* File: analog_output_sequencer_sva.sv */
// Purpose: Port assertions for the output sequencer
// Assumes: One clock domain, async active-low reset
// Notes: Bound to the design module
`timescale 1ns/1ps
`include "analog_output_sequencer_consts.vh"
module aos_checker (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] dac_chan,
  input wire dac_load,
  input wire running
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence cmd_wr;
    psel && penable && pready && pwrite && paddr == `REG_CMD;
  endsequence
  sequence go_cmd;
    cmd_wr ##0 (pwdata[`CMD_START] && !pwdata[`CMD_STOP] && !running);
  endsequence
  sequence halt_cmd;
    cmd_wr ##0 (pwdata[`CMD_STOP] && running);
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_start_runs: assert property (go_cmd |-> ##[1:2] running)
    else $error("start did not run");
  a_stop_halts: assert property (halt_cmd |-> ##[1:3] !running)
    else $error("stop did not halt");
  a_load_run: assert property ($rose(dac_load) |-> $past(running, 2))
    else $error("load while idle");
  a_first_chan: assert property ($rose(dac_load) |-> dac_chan == 2'h0)
    else $error("burst not at channel 0");
  a_chan_step: assert property (dac_load && $past(dac_load) |->
    dac_chan == $past(dac_chan) + 2'h1)
    else $error("channel order broken");
endmodule // aos_checker
bind analog_output_sequencer aos_checker i_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .dac_chan(dac_chan), .dac_load(dac_load),
  .running(running));

/* File: tb_analog_output_sequencer.sv */
// Purpose: Self-checking bench for the output sequencer
// Assumes: APB host model drives the bus
// Notes: A queue predicts every loaded output word
`timescale 1ns/1ps
`include "analog_output_sequencer_consts.vh"
module tb_analog_output_sequencer;
  logic pclk, presetn, ext_clk_in, ext_trig_in, psel, penable, pwrite;
  logic pready, pslverr, dac_load, running;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] dac_data;
  logic [1:0] dac_chan;
  int err_total, tests_run, seed;
  logic [15:0] exp_q[$];
  logic [15:0] pat[$];
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  apb_host i_host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  analog_output_sequencer i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in), .ext_trig_in(ext_trig_in),
    .dac_data(dac_data), .dac_chan(dac_chan), .dac_load(dac_load), .running(running));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hang;
    err_total++;
    wrap_up();
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    i_host.xfer(1'b1, a, d, q, e);
  endtask
  // Bit index below zero compares the whole word
  task automatic rd(logic [7:0] a, int b, logic [31:0] v);
    logic [31:0] q;
    logic e;
    i_host.xfer(1'b0, a, 32'h0, q, e);
    chk("reg", v, (b < 0) ? q : {31'h0, q[b]});
  endtask
  task automatic load(int n);
    logic [15:0] w;
    repeat (n) begin
      w = 16'($random(seed));
      exp_q.push_back(w);
      wr(`REG_DATA, {16'h0, w});
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (running !== 1'b0) begin
      n++;
      if (n > 20000) hang();
      @(posedge pclk);
    end
    // A burst started by the last tick still drains after the state goes idle
    repeat (6) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (dac_load === 1'b1) begin
      chk("dac_data", {16'h0, exp_q.size() != 0 ? exp_q.pop_front() : ~dac_data},
        {16'h0, dac_data});
    end
  end
  initial begin
    logic [31:0] q;
    logic e;
    seed = 32'hc743;
    err_total = 0;
    tests_run = 0;
    presetn = 1'b0;
    ext_clk_in = 1'b0;
    ext_trig_in = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk("dac_data", {16'h0, `DAC_MID}, {16'h0, dac_data});
    i_host.xfer(1'b0, 8'hfc, 32'h0, q, e);
    chk("pslverr", 32'h1, {31'h0, e});
    wr(`REG_PERIOD, 32'h4);
    wr(`REG_SAMPLES, 32'h3);
    wr(`REG_XFER_LEVEL, 32'h5);
    load(3);
    rd(`REG_STATUS, `ST_DATA_CNT, 1);
    wr(`REG_CMD, 32'h1);
    rd(`REG_STATUS, `ST_BUSY, 1);
    wait_idle();
    chk("left", 0, exp_q.size());
    rd(`REG_EVENTS, `EV_OP_END, 1);
    rd(`REG_EVENTS, `EV_START, 0);
    rd(`REG_EVENTS, `EV_XFER, 1);
    rd(`REG_FILL, -1, 0);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_SAMPLES, 32'h2);
    wr(`REG_REPEAT, 32'h2);
    wr(`REG_XFER_LEVEL, 32'h2);
    wr(`REG_EVENTS, 32'hffffffff);
    wr(`REG_CMD, 32'h8);
    load(2);
    pat = exp_q;
    exp_q = {pat, pat};
    wr(`REG_CMD, 32'h1);
    wr(`REG_DATA, 32'h1234);
    rd(`REG_STATUS, `ST_REFUSED, 1);
    wait_idle();
    chk("left", 0, exp_q.size());
    rd(`REG_REPEAT_DONE, -1, 2);
    rd(`REG_EVENTS, `EV_REP_END, 1);
    rd(`REG_EVENTS, `EV_XFER, 1);
    wr(`REG_REPEAT, 32'h0);
    wr(`REG_EVENTS, 32'hffffffff);
    exp_q = pat;
    repeat (5) exp_q = {exp_q, exp_q};
    wr(`REG_CMD, 32'h1);
    repeat (100) @(posedge pclk);
    chk("running", 1, {31'h0, running});
    wr(`REG_CMD, 32'h2);
    wait_idle();
    exp_q.delete();
    rd(`REG_EVENTS, `EV_OP_END, 0);
    wr(`REG_CMD, 32'h8);
    rd(`REG_REPEAT_DONE, -1, 0);
    rd(`REG_SAMPLE_CNT, -1, 0);
    rd(`REG_FILL, -1, 0);
    rd(`REG_STATUS, `ST_DATA_CNT, 0);
    wr(`REG_CTRL, 32'hb);
    wr(`REG_REPEAT, 32'h1);
    wr(`REG_EVENTS, 32'hffffffff);
    load(2);
    wr(`REG_CMD, 32'h1);
    rd(`REG_STATUS, `ST_TRIG_WAIT, 1);
    ext_trig_in <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(`REG_STATUS, `ST_TRIG_WAIT, 0);
    repeat (2) begin
      ext_clk_in <= 1'b1;
      repeat (7) @(posedge pclk);
      ext_clk_in <= 1'b0;
      repeat (7) @(posedge pclk);
    end
    wait_idle();
    ext_trig_in <= 1'b0;
    chk("left", 0, exp_q.size());
    rd(`REG_EVENTS, `EV_START, 1);
    wr(`REG_CMD, 32'h8);
    wr(`REG_CTRL, 32'h100);
    wr(`REG_PERIOD, 32'h1);
    wr(`REG_SAMPLES, 32'h4);
    load(8);
    wr(`REG_CMD, 32'h1);
    wait_idle();
    exp_q.delete();
    rd(`REG_STATUS, `ST_SCLK_ERR, 1);
    rd(`REG_EVENTS, `EV_SCLK_ERR, 1);
    wr(`REG_CMD, 32'h4);
    rd(`REG_STATUS, `ST_SCLK_ERR, 0);
    wr(`REG_CMD, 32'h8);
    wr(`REG_CTRL, 32'h40);
    wr(`REG_PERIOD, 32'h3e8);
    wr(`REG_CMD, 32'h1);
    wait_idle();
    rd(`REG_STATUS, `ST_CONV_ERR, 1);
    wr(`REG_CMD, 32'h4);
    rd(`REG_STATUS, `ST_CONV_ERR, 0);
    load(2);
    wr(`REG_CMD, 32'h1);
    for (int i = 0; i < 1030; i++) begin
      exp_q.push_back(16'(i));
      wr(`REG_DATA, 32'(i));
    end
    rd(`REG_STATUS, `ST_OVERFLOW, 1);
    chk("running", 1, {31'h0, running});
    wr(`REG_CMD, 32'h2);
    wait_idle();
    exp_q.delete();
    wr(`REG_CMD, 32'h8);
    wr(`REG_CTRL, 32'ha6);
    wr(`REG_SAMPLES, 32'h2);
    wr(`REG_EVENTS, 32'hffffffff);
    load(2);
    wr(`REG_CMD, 32'h1);
    ext_clk_in <= 1'b1;
    repeat (7) @(posedge pclk);
    chk("left", 2, exp_q.size());
    repeat (2) begin
      ext_clk_in <= 1'b0;
      repeat (7) @(posedge pclk);
      ext_clk_in <= 1'b1;
      repeat (7) @(posedge pclk);
    end
    rd(`REG_EVENTS, `EV_OP_END, 0);
    chk("running", 1, {31'h0, running});
    ext_trig_in <= 1'b1;
    repeat (7) @(posedge pclk);
    chk("running", 1, {31'h0, running});
    ext_trig_in <= 1'b0;
    wait_idle();
    chk("left", 0, exp_q.size());
    rd(`REG_EVENTS, `EV_OP_END, 1);
    wrap_up();
  end
endmodule // tb_analog_output_sequencer
